// ===== inc/wwl_pkg.sv
// Constants, register map and state type of the low-power window watchdog.
// Assumes a single 10 MHz system clock that also serves as the oscillator clock.
package wwl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_FREQ_MHZ = 10;
    localparam int unsigned PRESC_DIV_DEFAULT = 16384;
    localparam int unsigned WAKE_SHORT_CYC = 256;
    localparam int unsigned WAKE_LONG_CYC = 4096;
    localparam int unsigned RESET_PULSE_US = 30;
    localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_US * CLK_FREQ_MHZ;
    localparam int unsigned WAKE_CNT_W = 13;
    localparam int unsigned PULSE_CNT_W = 9;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map: offsets are word indices, byte address is four times that
    localparam logic [7:0] CTRL_INDEX = 8'h2A;
    localparam logic [7:0] WIN_INDEX = 8'h30;
    localparam logic [31:0] CTRL_BYTE_ADDR = {22'h000000, CTRL_INDEX, 2'h0};
    localparam logic [31:0] WIN_BYTE_ADDR = {22'h000000, WIN_INDEX, 2'h0};

    ////////////////////////////////////////////////////////////////////////////////
    // Fields and reset values
    localparam int unsigned CNT_W = 7;
    localparam int unsigned ACT_BIT = 7;
    localparam int unsigned CNT_TOP_BIT = 6;
    localparam logic [6:0] CNT_RESET = 7'h7F;
    localparam logic [6:0] WIN_RESET = 7'h7F;
    localparam logic [6:0] CNT_ROLL_FROM = 7'h40;
    localparam logic [6:0] CNT_ONE = 7'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        WWL_RUN,
        WWL_HALT,
        WWL_ACT_HALT,
        WWL_WAKE_WAIT
    } wwl_state_t;

endpackage : wwl_pkg

// ===== logic/wwl_prescaler.sv
// Free-running divider giving one tick per DIV clock cycles.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/10ps
module wwl_prescaler #(
    parameter int unsigned DIV = 16384
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic tick_out
);
    import wwl_pkg::*;

    localparam int unsigned W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_reg;

    // Unknown phase at a counter write gives the usual min/max timeout spread
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= (cnt_reg == LAST - W'(1));
        end
    end

endmodule : wwl_prescaler

// ===== logic/wwl_top.sv
// Window watchdog with its low-power mode handling and an AHB-Lite register slave.
// Assumes the power-mode logic pulses HALT_REQ_IN for a halt instruction and
// gives option bits and wake events as synchronous levels and pulses.
//
// Contract
// - Slow and wait modes do not slow the downcounter.
// - Plain halt: no reset, one decrement, then frozen and resets suppressed.
// - Interrupt wake from halt resumes counting after 256 or 4096 cycles.
// - Reset leaves the watchdog disabled unless the hardware option is set.
// - Halt with reset-on-halt and no oscillator interrupt gives a reset.
// - Halt with oscillator interrupt enabled enters active-halt, counter frozen.
// - Interrupt exit from active-halt resumes counting immediately.
// - Reset exit from active-halt resumes counting after 256 or 4096 cycles; the code always waits 256.
// - Hardware option keeps the watchdog active and ignores the activation bit.
// - Control and window registers reset to 7Fh; the code reads control as FFh under the hardware option.
// - Activation bit is set by software only, cleared only by reset.
// - Counter decrements once every 16384 oscillator cycles.
// - Active watchdog resets on counter roll from 40h to 3Fh.
// - Window register holds a 7-bit compare value, bit 7 reserved.
// - Reload while counter is above the window causes a reset.
// - Watchdog reset drives the reset pin low for 30 us.
// - Software option starts disabled; once enabled only reset disables.
`timescale 1ns/10ps
module wwl_top #(
    parameter int unsigned PRESC_DIV = wwl_pkg::PRESC_DIV_DEFAULT
) (
    input wire logic CLOCK_IN,
    input wire logic RESET_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire logic HW_WATCHDOG_IN,
    input wire logic RESET_ON_HALT_IN,
    input wire logic OSC_INT_ENABLE_IN,
    input wire logic LONG_WAKE_DELAY_IN,
    input wire logic HALT_REQ_IN,
    input wire logic EXT_INT_IN,
    input wire logic OSC_INT_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    output logic MCU_RESET_N_OUT,
    output logic HALTED_OUT,
    output wwl_pkg::wwl_state_t STATE_OUT
);
    import wwl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    wwl_state_t state_reg;
    wwl_state_t state_next;
    logic activation_reg;
    logic activation_next;
    logic [CNT_W-1:0] counter_reg;
    logic [CNT_W-1:0] counter_next;
    logic [CNT_W-1:0] window_reg;
    logic [CNT_W-1:0] window_next;
    logic [WAKE_CNT_W-1:0] wake_cnt_reg;
    logic [WAKE_CNT_W-1:0] wake_cnt_next;
    logic [PULSE_CNT_W-1:0] pulse_cnt_reg;
    logic dp_write_reg;
    logic [31:0] dp_addr_reg;
    logic addr_phase;
    logic ctrl_wr;
    logic win_wr;
    logic tick;
    logic wdg_active;
    logic dog_fire;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [WAKE_CNT_W-1:0] wake_delay(input logic long_sel);
        if (long_sel) begin
            return WAKE_CNT_W'(WAKE_LONG_CYC - 1);
        end
        return WAKE_CNT_W'(WAKE_SHORT_CYC - 1);
    endfunction : wake_delay

    function automatic logic [31:0] read_word(
        input logic [31:0] addr,
        input logic act,
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] win
    );
        if (addr == CTRL_BYTE_ADDR) begin
            return {24'h000000, act, cnt};
        end
        if (addr == WIN_BYTE_ADDR) begin
            // Reserved bit reads as zero
            return {25'h0000000, win};
        end
        return 32'h00000000;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////////////
    // Timebase

    // Divider follows the oscillator, not the CPU clock
    wwl_prescaler #(
        .DIV(PRESC_DIV)
    ) u_presc (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESET_N_IN),
        .tick_out(tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    assign addr_phase = HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ);
    assign ctrl_wr = dp_write_reg && (dp_addr_reg == CTRL_BYTE_ADDR);
    assign win_wr = dp_write_reg && (dp_addr_reg == WIN_BYTE_ADDR);

    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 32'h00000000;
        end else begin
            dp_write_reg <= addr_phase && HWRITE_IN;
            if (addr_phase) begin
                dp_addr_reg <= HADDR_IN;
            end
        end
    end

    // Read data taken from next-state values so a write just before is seen
    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            HRDATA_OUT <= 32'h00000000;
        end else if (addr_phase && !HWRITE_IN) begin
            HRDATA_OUT <= read_word(HADDR_IN, activation_next | HW_WATCHDOG_IN,
                                    counter_next, window_next);
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= HRESP_OKAY;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Activation and window

    // Hardware option forces the watchdog on
    assign wdg_active = activation_reg || HW_WATCHDOG_IN;

    always_comb begin
        activation_next = activation_reg;
        // Only a one written sets it
        if (ctrl_wr && HWDATA_IN[ACT_BIT]) begin
            activation_next = 1'b1;
        end
    end

    always_comb begin
        window_next = window_reg;
        if (win_wr) begin
            window_next = HWDATA_IN[CNT_W-1:0];
        end
    end

    // Both registers come up as 7Fh, control reading FFh under the hardware option
    // Reset is the only way back to disabled
    // Reset during halt restores the disabled state
    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            activation_reg <= 1'b0;
            window_reg <= WIN_RESET;
        end else begin
            activation_reg <= activation_next;
            window_reg <= window_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Downcounter

    always_comb begin
        counter_next = counter_reg;
        if (ctrl_wr) begin
            counter_next = HWDATA_IN[CNT_W-1:0];
        end else if (state_reg == WWL_RUN && HALT_REQ_IN && !OSC_INT_ENABLE_IN
                     && !RESET_ON_HALT_IN) begin
            // Single decrement on the way into halt
            counter_next = counter_reg - CNT_ONE;
        end else if (state_reg == WWL_RUN && tick) begin
            // Free-running, also while disabled
            counter_next = counter_reg - CNT_ONE;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            counter_reg <= CNT_RESET;
        end else begin
            counter_reg <= counter_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset causes; suppressed outside the run state

    always_comb begin
        dog_fire = 1'b0;
        if (state_reg == WWL_RUN && wdg_active) begin
            if (ctrl_wr && counter_reg > window_reg) begin
                dog_fire = 1'b1;
            end
            // Writing the top counter bit low is the software reset
            if (ctrl_wr && !HWDATA_IN[CNT_TOP_BIT]) begin
                dog_fire = 1'b1;
            end
            if (!ctrl_wr && tick && counter_reg == CNT_ROLL_FROM) begin
                dog_fire = 1'b1;
            end
        end
        if (state_reg == WWL_RUN && HALT_REQ_IN && !OSC_INT_ENABLE_IN
            && RESET_ON_HALT_IN) begin
            dog_fire = 1'b1;
        end
    end

    // Reset is the only outward action
    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            pulse_cnt_reg <= '0;
        end else if (dog_fire) begin
            pulse_cnt_reg <= PULSE_CNT_W'(RESET_PULSE_CYC);
        end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_reg <= pulse_cnt_reg - PULSE_CNT_W'(1);
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            MCU_RESET_N_OUT <= 1'b1;
        end else begin
            MCU_RESET_N_OUT <= !(dog_fire || pulse_cnt_reg > PULSE_CNT_W'(1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-mode sequencing

    always_comb begin
        state_next = state_reg;
        wake_cnt_next = wake_cnt_reg;
        case (state_reg)
            WWL_RUN: begin
                if (HALT_REQ_IN && OSC_INT_ENABLE_IN) begin
                    // Active-halt, no reset whatever the option
                    state_next = WWL_ACT_HALT;
                end else if (HALT_REQ_IN && !RESET_ON_HALT_IN) begin
                    state_next = WWL_HALT;
                end
            end
            WWL_HALT: begin
                if (EXT_INT_IN) begin
                    state_next = WWL_WAKE_WAIT;
                    wake_cnt_next = wake_delay(LONG_WAKE_DELAY_IN);
                end
            end
            WWL_ACT_HALT: begin
                if (EXT_INT_IN || OSC_INT_IN) begin
                    state_next = WWL_RUN;
                end
            end
            WWL_WAKE_WAIT: begin
                if (wake_cnt_reg == '0) begin
                    state_next = WWL_RUN;
                end else begin
                    wake_cnt_next = wake_cnt_reg - WAKE_CNT_W'(1);
                end
            end
            default: begin
                state_next = WWL_RUN;
            end
        endcase
    end

    // Every reset is followed by the start-up delay before counting
    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= WWL_WAKE_WAIT;
            wake_cnt_reg <= wake_delay(1'b0);
        end else begin
            state_reg <= state_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            HALTED_OUT <= 1'b0;
            STATE_OUT <= WWL_WAKE_WAIT;
        end else begin
            HALTED_OUT <= (state_next == WWL_HALT) || (state_next == WWL_ACT_HALT);
            STATE_OUT <= state_next;
        end
    end

endmodule : wwl_top

// ===== tb/wwl_checker.sv
// Port assertions for the low-power watchdog top.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
module wwl_checker
    import wwl_pkg::*;
#(
    parameter int unsigned PRESC_DIV = 16
) (
    input wire logic CLOCK_IN,
    input wire logic RESET_N_IN,
    input wire logic HALT_REQ_IN,
    input wire logic EXT_INT_IN,
    input wire logic OSC_INT_IN,
    input wire logic OSC_INT_ENABLE_IN,
    input wire logic RESET_ON_HALT_IN,
    input wire logic LONG_WAKE_DELAY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic MCU_RESET_N_OUT,
    input wire logic HALTED_OUT,
    input wire wwl_pkg::wwl_state_t STATE_OUT
);
    logic [8:0] low_cnt;
    logic [12:0] wait_cnt;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // Cycle counts too long for a repetition
    always_ff @(posedge CLOCK_IN) begin
        low_cnt <= (!RESET_N_IN || MCU_RESET_N_OUT) ? 9'h000 : low_cnt + 9'h001;
    end
    always_ff @(posedge CLOCK_IN) begin
        // Held at zero in reset so the start-up wait is counted from release
        wait_cnt <= (!RESET_N_IN || STATE_OUT != WWL_WAKE_WAIT) ? 13'h0000 :
                    wait_cnt + 13'h0001;
    end
    sequence s_halt_run;
        HALT_REQ_IN && STATE_OUT == WWL_RUN;
    endsequence
    sequence s_wake_done;
        STATE_OUT == WWL_RUN && $past(STATE_OUT) == WWL_WAKE_WAIT;
    endsequence
    a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT && HRDATA_OUT[31:8] == 24'h0)
        else $error("bus answer not okay");
    a_act_halt: assert property (s_halt_run ##0 OSC_INT_ENABLE_IN
        |=> STATE_OUT == WWL_ACT_HALT && HALTED_OUT) else $error("no active halt");
    a_plain_halt: assert property (s_halt_run ##0 !OSC_INT_ENABLE_IN && !RESET_ON_HALT_IN
        |=> STATE_OUT == WWL_HALT && HALTED_OUT) else $error("no halt");
    a_halt_reset: assert property (s_halt_run ##0 !OSC_INT_ENABLE_IN && RESET_ON_HALT_IN
        |=> !MCU_RESET_N_OUT) else $error("halt gave no reset");
    a_halt_quiet: assert property (STATE_OUT inside {WWL_HALT, WWL_ACT_HALT} && MCU_RESET_N_OUT
        |=> MCU_RESET_N_OUT) else $error("reset while halted");
    a_act_wake: assert property (STATE_OUT == WWL_ACT_HALT && (EXT_INT_IN || OSC_INT_IN)
        |=> STATE_OUT == WWL_RUN) else $error("active halt wake late");
    a_halt_wake: assert property (STATE_OUT == WWL_HALT && EXT_INT_IN
        |=> STATE_OUT == WWL_WAKE_WAIT) else $error("halt wake missed");
    a_wake_delay: assert property (s_wake_done |-> (LONG_WAKE_DELAY_IN ?
        wait_cnt inside {[4090:4102]} : wait_cnt inside {[250:262]})) else $error("wake delay");
    a_pulse_len: assert property ($rose(MCU_RESET_N_OUT) |-> low_cnt == 9'h12C)
        else $error("reset pulse length");
endmodule : wwl_checker

bind wwl_top wwl_checker #(.PRESC_DIV(PRESC_DIV)) u_chk (.CLOCK_IN(CLOCK_IN),
    .RESET_N_IN(RESET_N_IN), .HALT_REQ_IN(HALT_REQ_IN), .EXT_INT_IN(EXT_INT_IN),
    .OSC_INT_IN(OSC_INT_IN), .OSC_INT_ENABLE_IN(OSC_INT_ENABLE_IN),
    .RESET_ON_HALT_IN(RESET_ON_HALT_IN), .LONG_WAKE_DELAY_IN(LONG_WAKE_DELAY_IN),
    .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .MCU_RESET_N_OUT(MCU_RESET_N_OUT), .HALTED_OUT(HALTED_OUT), .STATE_OUT(STATE_OUT));

// ===== tb/wwl_power_model.sv
// Reset generator and power-mode pulses beside the watchdog.
// Assumes the bench calls pulse() from its own clocked sequence.
`timescale 1ns/10ps
module wwl_power_model (
    input wire logic clk_in,
    input wire logic por_n_in,
    input wire logic mcu_reset_n_in,
    output logic rst_n_out,
    output logic halt_req_out,
    output logic ext_int_out,
    output logic osc_int_out
);
    logic [2:0] hold_reg;
    logic last_reg;
    initial {halt_req_out, ext_int_out, osc_int_out} = 3'h0;
    // A finished watchdog pulse becomes a short system reset
    always_ff @(posedge clk_in) begin
        last_reg <= !por_n_in || mcu_reset_n_in;
        if (!por_n_in) hold_reg <= 3'h0;
        else if (mcu_reset_n_in && !last_reg) hold_reg <= 3'h4;
        else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
    end
    assign rst_n_out = por_n_in && hold_reg == 3'h0;
    task automatic pulse(input logic [2:0] which);
        @(posedge clk_in);
        {halt_req_out, ext_int_out, osc_int_out} <= which;
        @(posedge clk_in);
        {halt_req_out, ext_int_out, osc_int_out} <= 3'h0;
    endtask : pulse
endmodule : wwl_power_model

// ===== tb/wwl_top_test.sv
// Self-checking bench for the low-power window watchdog.
// Assumes the power model closes the reset loop after each watchdog pulse.
`timescale 1ns/10ps
module wwl_top_test;
    import wwl_pkg::*;
    logic clk = 1'b0, por_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic hw_opt = 1'b0, roh = 1'b0, oscillator_interrupt_enable = 1'b0, long_dly = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, q2;
    logic rst_n, halt_req, ext_int, osc_int, hready, hresp, mcu_rst_n, halted;
    wwl_state_t state;
    int n_mismatch = 0, checks = 0, n;
    always #50 clk = ~clk;
    // Short divider keeps the run brief
    wwl_top #(.PRESC_DIV(16)) uut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HW_WATCHDOG_IN(hw_opt),
        .RESET_ON_HALT_IN(roh), .OSC_INT_ENABLE_IN(oscillator_interrupt_enable), .LONG_WAKE_DELAY_IN(long_dly),
        .HALT_REQ_IN(halt_req), .EXT_INT_IN(ext_int), .OSC_INT_IN(osc_int),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .MCU_RESET_N_OUT(mcu_rst_n), .HALTED_OUT(halted), .STATE_OUT(state));
    wwl_power_model wm (.clk_in(clk), .por_n_in(por_n), .mcu_reset_n_in(mcu_rst_n),
        .rst_n_out(rst_n), .halt_req_out(halt_req), .ext_int_out(ext_int),
        .osc_int_out(osc_int));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // Released write data is inverted so stale values never match
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hsize <= 3'h2;
        hwrite <= w;
        hwdata <= ~hwdata;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic expect_reset(input int lim);
        n = 0;
        while (mcu_rst_n !== 1'b0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk("watchdog reset", 8'h01, {7'h0, n < lim});
        wait (rst_n === 1'b0);
        wait (rst_n === 1'b1);
        repeat (300) @(posedge clk);
    endtask : expect_reset
    task automatic halt_check(input wwl_state_t st);
        wm.pulse(3'h4);
        @(posedge clk);
        chk("state", {6'h0, st}, {6'h0, state});
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        q2 = q;
        repeat (100) @(posedge clk);
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        chk("frozen count", q2[7:0], q[7:0]);
        chk("no reset", 8'h01, {7'h0, mcu_rst_n});
    endtask : halt_check
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 30000);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        por_n <= 1'b1;
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        chk("control reset", 8'h7F, q[7:0]);
        bus(1'b0, WIN_BYTE_ADDR, 32'h0);
        chk("window reset", 8'h7F, q[7:0]);
        bus(1'b1, 32'h00000010, 32'hFF);
        bus(1'b0, 32'h00000010, 32'h0);
        chk("unmapped read", 8'h00, q[7:0]);
        repeat (300) @(posedge clk);
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        q2 = q;
        repeat (61) @(posedge clk);
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        chk("ticks in 64 cycles", 8'h04, q2[7:0] - q[7:0]);
        bus(1'b1, CTRL_BYTE_ADDR, 32'hFF);
        bus(1'b1, CTRL_BYTE_ADDR, 32'h7F);
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        chk("activation kept", 8'h01, {7'h0, q[7]});
        expect_reset(1500);
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        chk("activation after reset", 8'h00, {7'h0, q[7]});
        bus(1'b1, CTRL_BYTE_ADDR, 32'hFF);
        bus(1'b1, WIN_BYTE_ADDR, 32'h50);
        bus(1'b1, CTRL_BYTE_ADDR, 32'hFF);
        expect_reset(4);
        for (int i = 0; i < 2; i++) begin
            long_dly <= i[0];
            bus(1'b1, CTRL_BYTE_ADDR, 32'hFF);
            halt_check(WWL_HALT);
            wm.pulse(3'h2);
            n = 0;
            while (state !== WWL_RUN && n < 5000) begin
                @(posedge clk);
                n++;
            end
            chk("wake delay", 8'h01, {7'h0, n > (i ? 4088 : 248) && n < (i ? 4104 : 264)});
        end
        long_dly <= 1'b0;
        oscillator_interrupt_enable <= 1'b1;
        roh <= 1'b1;
        bus(1'b1, CTRL_BYTE_ADDR, 32'hFF);
        halt_check(WWL_ACT_HALT);
        wm.pulse(3'h1);
        @(posedge clk);
        chk("state after wake", {6'h0, WWL_RUN}, {6'h0, state});
        oscillator_interrupt_enable <= 1'b0;
        wm.pulse(3'h4);
        expect_reset(4);
        hw_opt <= 1'b1;
        bus(1'b1, CTRL_BYTE_ADDR, 32'h7F);
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        chk("hardware active", 8'h01, {7'h0, q[7]});
        por_n <= 1'b0;
        repeat (10) @(posedge clk);
        por_n <= 1'b1;
        bus(1'b0, CTRL_BYTE_ADDR, 32'h0);
        chk("control after reset", 8'hFF, q[7:0]);
        close_out();
    end
endmodule : wwl_top_test
